// File: src/dram_map.svh
// Purpose: Timing and field constants for the word-wide memory controller
// Assumes: 25 MHz controller clock
// Notes:   Least times round up to whole cycles, longest times round down
`ifndef DRAM_MAP_SVH
`define DRAM_MAP_SVH

`define CLK_PERIOD_NS        40
`define CYC_MIN(ns)          ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                              (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

// Word geometry: 256k words of 16 bits
`define WORD_ADDR_BITS       18
`define WORD_DATA_BITS       16
`define PIN_ADDR_BITS        10

// Refresh variants
`define ROWS_512_BITS        9
`define ROWS_1024_BITS       10
`define REFRESH_512_MS       8
`define REFRESH_1024_MS      16
`define NS_PER_MS            1000000

// Strobe timing, plain defaults
`define ROW_PRECHARGE_NS     60
`define ROW_TO_COLUMN_NS     20
`define COLUMN_PULSE_NS      20
`define COLUMN_PRECHARGE_NS  10
`define ROW_PRECHARGE_CYC    `CYC_MIN(`ROW_PRECHARGE_NS)
`define ROW_TO_COLUMN_CYC    `CYC_MIN(`ROW_TO_COLUMN_NS)
`define COLUMN_PULSE_CYC     `CYC_MIN(`COLUMN_PULSE_NS)
`define COLUMN_PRECHARGE_CYC `CYC_MIN(`COLUMN_PRECHARGE_NS)

// Read data passes two pin flops before capture
`define PIN_SYNC_CYC         2

`endif

// File: src/dram_pkg.sv
// Purpose: Types shared by the memory controller modules
// Assumes: Constants come from dram_map.svh
// Notes:   One-hot state codes
package dram_pkg;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_ROW    = 7'h02,
		ST_COL    = 7'h04,
		ST_PAGE   = 7'h08,
		ST_PRECH  = 7'h10,
		ST_REF    = 7'h20,
		ST_REFEND = 7'h40
	} ctrl_state_type;

	typedef logic [1:0] lane_type;

endpackage

// File: src/refresh_if.sv
// Purpose: Link between the access sequencer and the refresh scheduler
// Assumes: Single clock domain
// Notes:   Request stays up until acknowledged
`timescale 1ns/1ps
`default_nettype none
interface refresh_if #(parameter int ROW_BITS = 9);
	logic                pending;
	logic                ack;
	logic [ROW_BITS-1:0] row;

	modport scheduler (output pending, output row, input ack);
	modport sequencer (input pending, input row, output ack);
endinterface
`default_nettype wire

// File: src/refresh_timer.sv
// Purpose: Evenly spaced refresh requests with a stepping row address
// Assumes: INTERVAL_CYC below 4096
// Notes:   A tick that lands with an ack keeps the request pending
`timescale 1ns/1ps
`default_nettype none
module refresh_timer #(
	parameter int ROW_BITS     = 9,
	parameter int INTERVAL_CYC = 390
) (
	input  wire logic            clk,   // Controller clock
	input  wire logic            rst_n, // Async reset, active low
	refresh_if.scheduler         rif    // Request, ack and row
);
	logic [11:0]         tick_q, tick_d;
	logic                pend_q, pend_d;
	logic [ROW_BITS-1:0] row_q, row_d;
	logic                tick_done;

	assign tick_done = (tick_q == 12'(INTERVAL_CYC - 1));

	always_comb begin
		tick_d = tick_done ? 12'h000 : tick_q + 12'h001;
		// Set wins over the acknowledge
		pend_d = tick_done | (pend_q & ~rif.ack);
		row_d  = rif.ack ? row_q + ROW_BITS'(1) : row_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 12'h000;
			pend_q <= 1'b0;
			row_q  <= '0;
		end else begin
			tick_q <= tick_d;
			pend_q <= pend_d;
			row_q  <= row_d;
		end
	end

	assign rif.pending = pend_q;
	assign rif.row     = row_q;
endmodule
`default_nettype wire

// File: src/dram_ctrl.sv
// Purpose: Controller driving a 256k x 16 dynamic memory by its strobes
// Assumes: 25 MHz clock, one memory, early writes only
// Notes:   Row-only refresh; an open page closes on a miss, on any write or on refresh
//
// Overview of operation
// - The 512-row variant gets 512 refreshes in every 8 ms.
// - The 1024-row variant gets 1024 refreshes in every 16 ms.
// - With dual column strobes the column strobes pick which byte lanes answer.
// - Upper and lower bytes are never written one after the other in one cycle.
// - Early and late writes are never mixed in one cycle.
// - A word write drops both byte controls together.
// - A byte write drops only the control of the chosen lane.
// - Page-mode column strobes stay high for the column precharge minimum.
`timescale 1ns/1ps
`default_nettype none
`include "dram_map.svh"
module dram_ctrl #(
	parameter bit REFRESH_1024 = 1'b0, // 1: 1024 rows per 16 ms part
	parameter bit DUAL_WE      = 1'b0  // 1: dual write enable option
) (
	input  wire logic                         clk,        // 25 MHz clock
	input  wire logic                         rst_n,      // Async reset, low
	input  wire logic                         req,        // Access request
	input  wire logic                         req_write,  // 1 write, 0 read
	input  wire dram_pkg::lane_type           req_lanes,  // [1] upper, [0] lower
	input  wire logic [`WORD_ADDR_BITS-1:0]   req_addr,   // Word address
	input  wire logic [`WORD_DATA_BITS-1:0]   req_wdata,  // Write word
	output logic                              ready,      // Request taken now
	output logic [`WORD_DATA_BITS-1:0]        rdata,      // Read word
	output logic                              rvalid,     // Read word pulse
	output logic                              row_strobe_n,          // Row strobe
	output logic                              upper_byte_column_strobe_n, // Upper col
	output logic                              lower_byte_column_strobe_n, // Lower col
	output logic                              upper_write_enable_n,  // Upper write
	output logic                              lower_write_enable_n,  // Lower write
	output logic [`PIN_ADDR_BITS-1:0]         mem_addr,   // Multiplexed address
	output logic [`WORD_DATA_BITS-1:0]        dq_out,     // Data pins out
	output logic                              dq_oe,      // Data pins driven
	input  wire logic [`WORD_DATA_BITS-1:0]   dq_in       // Data pins in
);
	import dram_pkg::*;

	localparam int ROW_BITS = REFRESH_1024 ? `ROWS_1024_BITS : `ROWS_512_BITS;
	localparam int COL_BITS = `WORD_ADDR_BITS - ROW_BITS;
	localparam int PERIOD_MS = REFRESH_1024 ? `REFRESH_1024_MS : `REFRESH_512_MS;
	// Longest gap between refreshes, rounded down
	localparam int INTERVAL_CYC =
		(PERIOD_MS * `NS_PER_MS) / (`CLK_PERIOD_NS * (1 << ROW_BITS));
	localparam int READ_HOLD_CYC = `COLUMN_PULSE_CYC + `PIN_SYNC_CYC;

	refresh_if #(.ROW_BITS(ROW_BITS)) rif ();

	refresh_timer #(
		.ROW_BITS     (ROW_BITS),
		.INTERVAL_CYC (INTERVAL_CYC)
	) u_refresh (
		.clk   (clk),
		.rst_n (rst_n),
		.rif   (rif)
	);

	ctrl_state_type                state_q, state_d;
	logic [7:0]                    cnt_q, cnt_d;
	logic                          write_q, write_d;
	lane_type                      lanes_q, lanes_d;
	logic [`WORD_ADDR_BITS-1:0]    addr_q, addr_d;
	logic [`WORD_DATA_BITS-1:0]    wdata_q, wdata_d;
	logic                          pend_q, pend_d;
	logic                          ras_n_q, ras_n_d;
	lane_type                      cas_n_q, cas_n_d;
	lane_type                      we_n_q, we_n_d;
	logic [`PIN_ADDR_BITS-1:0]     maddr_q, maddr_d;
	logic                          oe_q, oe_d;
	logic                          ready_q, ready_d;
	logic [`WORD_DATA_BITS-1:0]    rdata_q, rdata_d;
	logic                          rvalid_q, rvalid_d;
	logic [`WORD_DATA_BITS-1:0]    dq_s1_q, dq_s2_q;
	logic                          take, cnt_done, page_hit;
	lane_type                      req_lanes_fix;

	assign cnt_done = (cnt_q == 8'h00);
	assign take     = req & ready_q;
	// No lane chosen is read as a whole word
	assign req_lanes_fix = (req_lanes == 2'b00) ? 2'b11 : req_lanes;
	assign page_hit = ~req_write &
		(req_addr[`WORD_ADDR_BITS-1 -: ROW_BITS] == addr_q[`WORD_ADDR_BITS-1 -: ROW_BITS]);

	function automatic logic [`PIN_ADDR_BITS-1:0] row_of(input logic [`WORD_ADDR_BITS-1:0] a);
		row_of = `PIN_ADDR_BITS'(a[`WORD_ADDR_BITS-1 -: ROW_BITS]);
	endfunction

	function automatic logic [`PIN_ADDR_BITS-1:0] col_of(input logic [`WORD_ADDR_BITS-1:0] a);
		col_of = `PIN_ADDR_BITS'(a[COL_BITS-1:0]);
	endfunction

	always_comb begin
		state_d  = state_q;
		cnt_d    = cnt_q == 8'h00 ? 8'h00 : cnt_q - 8'h01;
		write_d  = write_q;
		lanes_d  = lanes_q;
		addr_d   = addr_q;
		wdata_d  = wdata_q;
		pend_d   = pend_q;
		ras_n_d  = ras_n_q;
		cas_n_d  = cas_n_q;
		we_n_d   = we_n_q;
		maddr_d  = maddr_q;
		oe_d     = oe_q;
		ready_d  = 1'b0;
		rdata_d  = rdata_q;
		rvalid_d = 1'b0;
		rif.ack  = 1'b0;
		if (take) begin
			write_d = req_write;
			lanes_d = req_lanes_fix;
			addr_d  = req_addr;
			wdata_d = req_wdata;
		end
		case (state_q)
			ST_IDLE: begin
				// A request already shown ready goes first, else it would be lost
				if (rif.pending && !take) begin
					// Row-only refresh of the next row in turn
					state_d = ST_REF;
					ras_n_d = 1'b0;
					maddr_d = `PIN_ADDR_BITS'(rif.row);
					cnt_d   = 8'(`ROW_TO_COLUMN_CYC + `COLUMN_PULSE_CYC - 1);
				end else if (take) begin
					state_d = ST_ROW;
					ras_n_d = 1'b0;
					maddr_d = row_of(req_addr);
					cnt_d   = 8'(`ROW_TO_COLUMN_CYC - 1);
					oe_d    = req_write;
					// Write enable falls before any column strobe: early write only
					if (req_write)
						we_n_d = DUAL_WE ? ~req_lanes_fix : 2'b00;
				end else begin
					ready_d = 1'b1;
				end
			end
			ST_ROW: begin
				if (cnt_done) begin
					state_d = ST_COL;
					maddr_d = col_of(addr_q);
					// Full word latched on the strobe falls, lanes picked by strobes, or by write enables on DUAL_WE writes
					cas_n_d = (DUAL_WE && write_q) ? 2'b00 : ~lanes_q;
					cnt_d   = write_q ? 8'(`COLUMN_PULSE_CYC - 1) : 8'(READ_HOLD_CYC - 1);
				end
			end
			ST_COL: begin
				if (cnt_done) begin
					cas_n_d = 2'b11;
					we_n_d  = 2'b11;
					if (write_q) begin
						// A write always ends its row cycle; no second lane follows
						state_d = ST_PRECH;
						ras_n_d = 1'b1;
						oe_d    = 1'b0;
						cnt_d   = 8'(`ROW_PRECHARGE_CYC - 1);
					end else begin
						state_d  = ST_PAGE;
						rdata_d  = dq_s2_q;
						rvalid_d = 1'b1;
						cnt_d    = 8'(`COLUMN_PRECHARGE_CYC - 1);
					end
				end
			end
			ST_PAGE: begin
				if (rif.pending && !take) begin
					state_d = ST_PRECH;
					ras_n_d = 1'b1;
					cnt_d   = 8'(`ROW_PRECHARGE_CYC - 1);
				end else if (take && page_hit) begin
					state_d = ST_ROW;
					cnt_d   = 8'h00;
				end else if (take) begin
					state_d = ST_PRECH;
					pend_d  = 1'b1;
					ras_n_d = 1'b1;
					cnt_d   = 8'(`ROW_PRECHARGE_CYC - 1);
				end else begin
					// Next column strobe waits out the column precharge
					ready_d = (cnt_q <= 8'h01) & ~rif.pending;
				end
			end
			ST_PRECH: begin
				if (cnt_done) begin
					if (pend_q) begin
						pend_d  = 1'b0;
						state_d = ST_ROW;
						ras_n_d = 1'b0;
						maddr_d = row_of(addr_q);
						cnt_d   = 8'(`ROW_TO_COLUMN_CYC - 1);
						oe_d    = write_q;
						if (write_q)
							we_n_d = DUAL_WE ? ~lanes_q : 2'b00;
					end else begin
						state_d = ST_IDLE;
						ready_d = ~rif.pending;
					end
				end
			end
			ST_REF: begin
				if (cnt_done) begin
					state_d = ST_REFEND;
					ras_n_d = 1'b1;
					rif.ack = 1'b1;
					cnt_d   = 8'(`ROW_PRECHARGE_CYC - 1);
				end
			end
			ST_REFEND: begin
				if (cnt_done) begin
					state_d = ST_IDLE;
					ready_d = ~rif.pending;
				end
			end
			default: begin
				state_d = ST_IDLE;
				ras_n_d = 1'b1;
				cas_n_d = 2'b11;
				we_n_d  = 2'b11;
				oe_d    = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= ST_IDLE;
			cnt_q    <= 8'h00;
			write_q  <= 1'b0;
			lanes_q  <= 2'b00;
			addr_q   <= '0;
			wdata_q  <= '0;
			pend_q   <= 1'b0;
			ras_n_q  <= 1'b1;
			cas_n_q  <= 2'b11;
			we_n_q   <= 2'b11;
			maddr_q  <= '0;
			oe_q     <= 1'b0;
			ready_q  <= 1'b0;
			rdata_q  <= '0;
			rvalid_q <= 1'b0;
			dq_s1_q  <= '0;
			dq_s2_q  <= '0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			write_q  <= write_d;
			lanes_q  <= lanes_d;
			addr_q   <= addr_d;
			wdata_q  <= wdata_d;
			pend_q   <= pend_d;
			ras_n_q  <= ras_n_d;
			cas_n_q  <= cas_n_d;
			we_n_q   <= we_n_d;
			maddr_q  <= maddr_d;
			oe_q     <= oe_d;
			ready_q  <= ready_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
			dq_s1_q  <= dq_in;
			dq_s2_q  <= dq_s1_q;
		end
	end

	assign ready                      = ready_q;
	assign rdata                      = rdata_q;
	assign rvalid                     = rvalid_q;
	assign row_strobe_n               = ras_n_q;
	assign upper_byte_column_strobe_n = cas_n_q[1];
	assign lower_byte_column_strobe_n = cas_n_q[0];
	assign upper_write_enable_n       = we_n_q[1];
	assign lower_write_enable_n       = we_n_q[0];
	assign mem_addr                   = maddr_q;
	assign dq_out                     = wdata_q;
	assign dq_oe                      = oe_q;
endmodule
`default_nettype wire

// File: dv/dram_ctrl_sva.sv
// Purpose: Strobe order, walk and refresh checks at the controller pins
// Assumes: REFRESH_1024 = 0, DUAL_WE = 0, default strobe timing
// Notes:   A row cycle with no column strobe counts as a refresh
`timescale 1ns/1ps
`default_nettype none
`include "dram_map.svh"
module dram_ctrl_sva (
	input wire logic                       clk,                        // Clock
	input wire logic                       rst_n,                      // Reset, low
	input wire logic                       req,                        // Request
	input wire logic                       req_write,                  // Write
	input wire dram_pkg::lane_type         req_lanes,                  // Lanes
	input wire logic                       ready,                      // Taken
	input wire logic                       rvalid,                     // Read pulse
	input wire logic                       row_strobe_n,               // Row strobe
	input wire logic                       upper_byte_column_strobe_n, // Upper col
	input wire logic                       lower_byte_column_strobe_n, // Lower col
	input wire logic                       upper_write_enable_n,       // Upper we
	input wire logic                       lower_write_enable_n,       // Lower we
	input wire logic [`PIN_ADDR_BITS-1:0]  mem_addr,                   // Address
	input wire logic                       dq_oe                       // Data out
);
	import dram_pkg::*;
	// Interval plus one access, page close and the refresh itself
	localparam int REF_GAP = 420;
	wire logic rs = row_strobe_n;
	wire logic uc = upper_byte_column_strobe_n;
	wire logic lc = lower_byte_column_strobe_n;
	wire logic uw = upper_write_enable_n;
	wire logic lw = lower_write_enable_n;
	logic        rs_q, seen_q, seen_d, have_q, have_d, up_q, up_d, lo_q, lo_d, take, ref_end;
	logic [8:0]  frow_q, frow_d, last_q, last_d;
	logic [10:0] gap_q, gap_d;
	always_comb begin
		take    = req && ready;
		ref_end = rs && !rs_q && !seen_q;
		seen_d  = (!rs && rs_q) ? 1'b0 : (seen_q || (!rs && !(uc && lc)));
		frow_d  = (!rs && rs_q) ? mem_addr[8:0] : frow_q;
		last_d  = ref_end ? frow_q : last_q;
		have_d  = have_q || ref_end;
		gap_d   = ref_end ? 11'h0 : gap_q + 11'h1;
		up_d    = take ? (req_lanes[1] || req_lanes == 2'h0) : up_q;
		lo_d    = take ? (req_lanes[0] || req_lanes == 2'h0) : lo_q;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{rs_q, seen_q, have_q, up_q, lo_q} <= 5'h11;
			{frow_q, last_q, gap_q} <= 29'h0;
		end else begin
			{rs_q, seen_q, have_q, up_q, lo_q} <= {rs, seen_d, have_d, up_d, lo_d};
			{frow_q, last_q, gap_q} <= {frow_d, last_d, gap_d};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence w_open; !rs && dq_oe && !uw && !lw; endsequence
	sequence col_pick; !rs && uc == !up_q && lc == !lo_q; endsequence
	sequence all_high; rs && uc && lc && !dq_oe; endsequence
	// A refresh due at the end keeps ready low and opens its row next
	property w_walk;
		take && req_write && rs |=> w_open ##1 col_pick ##1 all_high [*2] ##1
			(ready or (!ready ##1 !rs));
	endproperty
	property r_walk;
		take && !req_write && rs |=> !rs ##1 col_pick [*3] ##1 (rvalid && uc && lc);
	endproperty
	write_walk_a: assert property (w_walk) else $error("write strobe walk wrong");
	read_walk_a: assert property (r_walk) else $error("read strobe walk wrong");
	ready_drop_a: assert property (take |=> !ready) else $error("ready held after take");
	col_in_row_a: assert property (($fell(uc) || $fell(lc)) |-> !rs)
		else $error("column strobe outside row");
	one_write_a: assert property (($fell(uc) || $fell(lc)) && !uw |->
		!seen_q && $past(uc) && $past(lc)) else $error("bytes written in turn");
	early_write_a: assert property ($fell(lw) || $fell(uw) |-> uc && lc)
		else $error("write enable fell late");
	col_prech_a: assert property ($rose(uc) |-> !$fell(lc) ##1 uc)
		else $error("column precharge too short");
	ref_gap_a: assert property (gap_q < REF_GAP) else $error("refresh late");
	ref_step_a: assert property (ref_end && have_q |-> frow_q == last_q + 9'h1)
		else $error("refresh row did not step");
endmodule
`default_nettype wire

// File: dv/word_mem_model.sv
// Purpose: Behavioural 256k x 16 memory answering the controller strobes
// Assumes: 9 row and 9 column bits, no pull on the data pins
// Notes:   Released data lanes flip so stale data never passes as read
`timescale 1ns/1ps
`default_nettype none
module word_mem_model (
	input  wire logic        row_strobe_n, // Row strobe
	input  wire logic        up_col_n,     // Upper column strobe
	input  wire logic        lo_col_n,     // Lower column strobe
	input  wire logic        up_we_n,      // Upper write enable
	input  wire logic        lo_we_n,      // Lower write enable
	input  wire logic [9:0]  mem_addr,     // Multiplexed address
	input  wire logic [15:0] dq_out,       // Data from controller
	input  wire logic        dq_oe,        // Controller drives data
	output logic      [15:0] dq_in         // Data to controller
);
	logic [15:0] cells [int];
	logic [8:0]  row_q;
	int          a;
	initial dq_in = 16'h0;
	always @(negedge row_strobe_n) #1 row_q = mem_addr[8:0];
	always @(negedge up_col_n or negedge lo_col_n) begin
		#1 a = {row_q, mem_addr[8:0]};
		if (!cells.exists(a)) cells[a] = a[15:0] ^ 16'h5a3c;
		if (!up_col_n && !up_we_n) cells[a][15:8] = dq_out[15:8];
		if (!lo_col_n && !lo_we_n) cells[a][7:0] = dq_out[7:0];
	end
	always @(up_col_n or lo_col_n) begin
		#2;
		dq_in[15:8] = (up_col_n || dq_oe) ? ~dq_in[15:8] : cells[a][15:8];
		dq_in[7:0] = (lo_col_n || dq_oe) ? ~dq_in[7:0] : cells[a][7:0];
	end
endmodule
`default_nettype wire

// File: dv/tb_word_wide_dram_byte_write_control.sv
// Purpose: Lane codes, page byte reads, random traffic and refresh count
// Assumes: Default parameters, 512-row part, dual column strobes
// Notes:   Lanes not selected on a read are not compared
`timescale 1ns/1ps
`default_nettype none
`include "dram_map.svh"
module tb_word_wide_dram_byte_write_control;
	import dram_pkg::*;
	logic                       clk = 1'b0, rst_n = 1'b0, req = 1'b0, req_write = 1'b0;
	lane_type                   req_lanes = 2'h0;
	logic [`WORD_ADDR_BITS-1:0] req_addr = 18'h0;
	logic [15:0]                req_wdata = 16'h0, rdata, dq_out, dq_in;
	logic                       ready, rvalid, rs, uc, lc, uw, lw, dq_oe;
	logic [9:0]                 mem_addr;
	int                         n_errors = 0, comparisons = 0, seed = 80, nref = 0, a;
	logic [15:0]                ref_mem [int];
	always #20 clk = ~clk;
	always @(negedge rs) nref++;
	dram_ctrl DUT (.clk(clk), .rst_n(rst_n), .req(req), .req_write(req_write),
		.req_lanes(req_lanes), .req_addr(req_addr), .req_wdata(req_wdata), .ready(ready),
		.rdata(rdata), .rvalid(rvalid), .row_strobe_n(rs), .upper_byte_column_strobe_n(uc),
		.lower_byte_column_strobe_n(lc), .upper_write_enable_n(uw),
		.lower_write_enable_n(lw), .mem_addr(mem_addr), .dq_out(dq_out), .dq_oe(dq_oe),
		.dq_in(dq_in));
	word_mem_model mem (.row_strobe_n(rs), .up_col_n(uc), .lo_col_n(lc), .up_we_n(uw),
		.lo_we_n(lw), .mem_addr(mem_addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
	function automatic logic [15:0] lane_mask(lane_type l);
		return (l == 2'h0) ? 16'hffff : {{8{l[1]}}, {8{l[0]}}};
	endfunction
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Holds the request until ready is seen high at an edge
	task automatic access(logic wr, lane_type l, int ad, logic [15:0] d);
		int          n;
		logic [15:0] m, e;
		m = lane_mask(l);
		e = ref_mem.exists(ad) ? ref_mem[ad] : (ad[15:0] ^ 16'h5a3c);
		@(posedge clk) #2;
		{req, req_write, req_lanes, req_addr, req_wdata} = {1'b1, wr, l, ad[17:0], d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ready !== 1'b1 && n < 50);
		#2 req = 1'b0;
		check("request taken", 16'(n < 50), 16'h1);
		if (wr) begin
			ref_mem[ad] = (e & ~m) | (d & m);
		end else begin
			n = 0;
			do begin
				@(posedge clk) #2;
				n++;
			end while (rvalid !== 1'b1 && n < 20);
			check("read word", rdata & m, e & m);
		end
	endtask
	initial begin
		#(40 * 20000);
		n_errors++;
		test_done();
	end
	initial begin
		repeat (20) @(posedge clk);
		#2 rst_n = 1'b1;
		// Every lane code on one boundary word, upper then lower as two writes
		for (int l = 0; l < 4; l++) begin
			access(1'b1, 2'(3 - l), 18'h3ffff, 16'($random(seed)));
			access(1'b0, 2'h3, 18'h3ffff, 16'h0);
		end
		$display("test lane codes done");
		// Page byte reads, upper then lower, last column of the row
		access(1'b0, 2'h2, 18'h00600, 16'h0);
		access(1'b0, 2'h1, 18'h00605, 16'h0);
		access(1'b0, 2'h2, 18'h007ff, 16'h0);
		$display("test page byte reads done");
		for (int i = 0; i < 200; i++) begin
			a = $random(seed) & 32'h0603;
			access(1'($random(seed)), 2'($random(seed)), a, 16'($random(seed)));
		end
		$display("test random traffic done");
		repeat (8) @(posedge clk);
		nref = 0;
		repeat (1000) @(posedge clk);
		check("refresh count", 16'(nref >= 2 && nref <= 3), 16'h1);
		$display("test idle refresh done");
		test_done();
	end
endmodule
bind dram_ctrl dram_ctrl_sva checks (.clk(clk), .rst_n(rst_n), .req(req),
	.req_write(req_write), .req_lanes(req_lanes), .ready(ready), .rvalid(rvalid),
	.row_strobe_n(row_strobe_n), .upper_byte_column_strobe_n(upper_byte_column_strobe_n),
	.lower_byte_column_strobe_n(lower_byte_column_strobe_n),
	.upper_write_enable_n(upper_write_enable_n),
	.lower_write_enable_n(lower_write_enable_n), .mem_addr(mem_addr), .dq_oe(dq_oe));
`default_nettype wire
